// *** hdl/switch_cfg_pkg.sv ***
// constants and carriers for the configuration access router
package switch_cfg_pkg;
   localparam int          PORT_W        = 3;
   localparam int          WIN_LSB       = 17;
   localparam logic [11:0] LEGACY_LAST   = 12'h0ff;
   localparam logic [11:0] BAR_LO_OFF    = 12'h010;
   localparam logic [11:0] BAR_HI_OFF    = 12'h014;
   localparam logic [11:0] BUSNUM_OFF    = 12'h018;
   localparam logic [11:0] EXT_STD_FIRST = 12'h100;
   localparam logic [11:0] EXT_STD_LAST  = 12'h1c7;
   localparam logic [11:0] AER_FIRST     = 12'hfb4;
   localparam logic [11:0] TYPED_OFF     = 12'h1f0;
   localparam logic [11:0] W1S_CLR_OFF   = 12'h1f4;
   localparam logic [11:0] READ_ZERO_OFF = 12'h1f8;
   localparam logic [11:0] SHADOW_OFF    = 12'h6c0;
   localparam logic [11:0] SHADOW_LAST   = 12'h6e4;
   localparam int          SHADOW_WORDS  = 10;
   localparam logic [31:0] BASE_LO_MASK  = 32'hfffe0000;
   localparam logic [31:0] BASE_LO_TYPE  = 32'h00000004;
   localparam logic [23:0] BUSNUM_RST    = 24'h000000;
   localparam logic [31:0] TY_RW         = 32'h0000000f;
   localparam logic [31:0] TY_W1C        = 32'h000000f0;
   localparam logic [31:0] TY_SRW        = 32'h00000f00;
   localparam logic [31:0] TY_SW1C       = 32'h0000f000;
   localparam logic [31:0] TY_W1S        = 32'h000f0000;
   localparam logic [31:0] TY_HWI        = 32'h0f000000;
   localparam logic [31:0] TY_STICKY_RO  = 32'h30000000;
   localparam logic [31:0] TY_RSVD       = 32'hc0f00000;
   localparam logic [31:0] TY_STICKY     = 32'h3f0fff00;
   localparam logic [31:0] TY_RST        = 32'h00000000;
   localparam logic [2:0]  CPL_SC        = 3'h0;
   localparam logic [2:0]  CPL_UR        = 3'h1;

   typedef enum logic [1:0] {REQ_CFG0, REQ_CFG1, REQ_MEM} req_kind_t;
   typedef enum logic {MECH_LEGACY, MECH_ENHANCED} mech_t;
   typedef enum logic [2:0] {RT_LOCAL, RT_FWD0, RT_FWD1, RT_UR, RT_ZERO} route_t;

   typedef struct packed {
      req_kind_t   kind;
      mech_t       mech;
      logic [7:0]  bus;
      logic [4:0]  dev;
      logic [2:0]  func;
      logic [11:0] offset;
      logic [63:0] addr;
      logic        we;
      logic [31:0] wdata;
   } cfg_req_t;

   typedef struct packed {
      logic [2:0]  port;
      logic        type0;
      logic [7:0]  bus;
      logic [4:0]  dev;
      logic [2:0]  func;
      logic [11:0] offset;
      logic        we;
      logic [31:0] wdata;
   } fwd_req_t;

   typedef struct packed {
      logic [2:0]  status;
      logic [31:0] rdata;
   } cpl_t;
endpackage : switch_cfg_pkg

// *** hdl/switch_config_access_router.sv ***
// configuration access decode, routing, memory window and typed registers
// Overview of operation
// - every port has 4 KB config space: 00h-FFh legacy, rest extended
// - legacy config access reaches only bytes 00h-FFh; beyond needs other mechanisms
// - upstream port captures bus and device numbers from type 0 config writes
// - type 1 to internal bus becomes type 0 access to matching downstream bridge
// - internal bus request with unknown device number completes Unsupported Request
// - type 1 inside a downstream secondary-subordinate range is forwarded there
// - secondary bus with device 0 is converted to type 0 before forwarding
// - secondary bus with nonzero device is dropped and reported Unsupported Request
// - bus beyond secondary but within subordinate forwards type 1 unchanged
// - enhanced mechanism reaches standard regions, not vendor registers above 100h
// - upstream base registers at 10h and 14h claim one 128 KB window
// - each port owns one 4 KB window slice, offsets equal config offsets
// - window decodes five ports; space above is reserved up to 128 KB
// - base register writes are copied into port 0 shadow slots 6C0h and 6C4h
// - hardware-initialized fields load once, then read-only until fundamental reset
// - write-one-clear bits read status; 1 clears, 0 leaves unchanged
// - sticky fields survive hot reset; sticky read-only not reinitialized by it
// - write-one-set: 1 enables control, 0 ignored, paired register clears
// - reserved-preserve bits read 0; software writes back what it read
// - reserved-zero bits read 0; software writes 0
// - read-zero register always reads 0 and accepts writes
module switch_config_access_router
   import switch_cfg_pkg::*;
#(
   parameter int         NUM_PORTS = 5,
   parameter logic [2:0] UP_PORT   = 3'h0
) (
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic        hot_reset,
   input  wire logic        req_valid,
   input  wire cfg_req_t    req,
   input  wire logic        ld_valid,
   input  wire logic [2:0]  ld_port,
   input  wire logic [11:0] ld_offset,
   input  wire logic [31:0] ld_data,
   input  wire logic        ld_done,
   input  wire logic [7:0]  ev_set [NUM_PORTS],
   input  wire logic [1:0]  sticky_ro_in [NUM_PORTS],
   output logic             cpl_valid,
   output cpl_t             cpl,
   output logic             fwd_valid,
   output fwd_req_t         fwd,
   output logic             loc_valid,
   output logic [2:0]       loc_port,
   output logic [7:0]       cap_bus,
   output logic [4:0]       cap_dev
);

   localparam logic [3:0] SH_LO = {UP_PORT, 1'b0};
   localparam logic [3:0] SH_HI = {UP_PORT, 1'b1};

   logic [23:0] bus_reg    [NUM_PORTS];
   logic [31:0] ty_reg     [NUM_PORTS];
   logic [31:0] shadow_reg [SHADOW_WORDS];
   logic [31:0] bar_lo_reg;
   logic [31:0] bar_hi_reg;
   logic        hw_locked_reg;

   // request decode
   logic [7:0]           int_bus;
   logic                 dev_ok;
   logic                 win_hit;
   logic [4:0]           slice;
   logic                 slice_ok;
   logic                 ext_std;
   logic                 enh_vendor;
   logic [11:0]          cfg_off;
   logic [NUM_PORTS-1:0] rng_hit;
   logic [2:0]           rng_port;
   logic                 rng_any;
   logic                 sec_match;

   assign int_bus  = bus_reg[UP_PORT][15:8];
   assign dev_ok   = req.dev < 5'(NUM_PORTS) && req.dev[2:0] != UP_PORT;
   assign win_hit  = req.addr[63:WIN_LSB] == {bar_hi_reg, bar_lo_reg[31:WIN_LSB]};
   assign slice    = req.addr[16:12];
   assign slice_ok = slice < 5'(NUM_PORTS);
   assign ext_std  = (req.offset >= EXT_STD_FIRST && req.offset <= EXT_STD_LAST)
                     || req.offset >= AER_FIRST;
   // vendor space above 100h is hidden from the enhanced mechanism
   assign enh_vendor = req.mech == MECH_ENHANCED && req.offset >= EXT_STD_FIRST
                       && !ext_std;
   // legacy requests carry no extended offset bits
   assign cfg_off  = req.mech == MECH_LEGACY ?
                     {4'h0, req.offset[7:0]} : req.offset;

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_rng
      assign rng_hit[p] = 3'(p) != UP_PORT && req.bus >= bus_reg[p][15:8]
                          && req.bus <= bus_reg[p][23:16];
   end

   always_comb begin
      rng_port = 3'h0;
      rng_any  = 1'b0;
      for (int p = NUM_PORTS - 1; p >= 0; p--) begin
         if (rng_hit[p]) begin
            rng_port = 3'(p);
            rng_any  = 1'b1;
         end
      end
   end

   assign sec_match = req.bus == bus_reg[rng_port][15:8];

   route_t      route;
   logic [2:0]  acc_port;
   logic [11:0] acc_off;

   always_comb begin
      route    = RT_UR;
      acc_port = UP_PORT;
      acc_off  = cfg_off;
      unique case (req.kind)
         REQ_CFG0: route = enh_vendor ? RT_ZERO : RT_LOCAL;
         REQ_CFG1: begin
            if (req.bus == int_bus) begin
               acc_port = req.dev[2:0];
               route    = !dev_ok ? RT_UR : enh_vendor ? RT_ZERO : RT_LOCAL;
            end else if (rng_any) begin
               if (!sec_match) route = RT_FWD1;
               else if (req.dev == 5'h0) route = RT_FWD0;
               else route = RT_UR;
            end
         end
         REQ_MEM: begin
            acc_port = slice[2:0];
            acc_off  = req.addr[11:0];
            route    = !win_hit ? RT_UR : slice_ok ? RT_LOCAL : RT_ZERO;
         end
         default: route = RT_UR;
      endcase
   end

   // register write selection, software before serial load
   logic                 acc_wr;
   logic                 port_ok;
   logic [NUM_PORTS-1:0] sw_hit;
   logic [NUM_PORTS-1:0] ld_hit;
   logic [NUM_PORTS-1:0] wr_hit;
   logic [11:0]          w_off [NUM_PORTS];
   logic [31:0]          w_dat [NUM_PORTS];

   assign acc_wr  = req_valid && route == RT_LOCAL && req.we && !hot_reset;
   assign port_ok = acc_port < 3'(NUM_PORTS);

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_wsel
      assign sw_hit[p] = acc_wr && acc_port == 3'(p);
      assign ld_hit[p] = ld_valid && ld_port == 3'(p) && !hot_reset;
      assign wr_hit[p] = sw_hit[p] || ld_hit[p];
      assign w_off[p]  = sw_hit[p] ? acc_off : ld_offset;
      assign w_dat[p]  = sw_hit[p] ? req.wdata : ld_data;
   end

   // access-type behaviour of the typed register
   function automatic logic [31:0] typed_next(input logic [31:0] cur,
                                              input logic        sw_wr,
                                              input logic        sw_clr,
                                              input logic        ld_wr,
                                              input logic        locked,
                                              input logic [31:0] wd,
                                              input logic [7:0]  ev,
                                              input logic [1:0]  sro);
      logic [31:0] n;
      n = cur;
      if (sw_wr || ld_wr) n = (n & ~(TY_RW | TY_SRW)) | (wd & (TY_RW | TY_SRW));
      if (sw_wr) n = (n & ~(wd & (TY_W1C | TY_SW1C))) | (wd & TY_W1S);
      if (sw_clr) n = n & ~(wd & TY_W1S);
      if (ld_wr && !locked) n = (n & ~TY_HWI) | (wd & TY_HWI);
      // status events land after the clear so a set in the same cycle wins
      n = n | {16'h0000, ev[7:4], 4'h0, ev[3:0], 4'h0};
      n = (n & ~TY_STICKY_RO) | {2'b00, sro, 28'h0000000};
      return n & ~TY_RSVD;
   endfunction : typed_next

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         hw_locked_reg <= 1'b0;
      end else if (ld_done) begin
         hw_locked_reg <= 1'b1;
      end
   end

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      logic [31:0] ty_next;
      assign ty_next = typed_next(ty_reg[p],
                                  sw_hit[p] && w_off[p] == TYPED_OFF,
                                  sw_hit[p] && w_off[p] == W1S_CLR_OFF,
                                  !sw_hit[p] && ld_hit[p] && w_off[p] == TYPED_OFF,
                                  hw_locked_reg, w_dat[p], ev_set[p], sticky_ro_in[p]);

      always_ff @(posedge mclk or negedge rstn) begin
         if (!rstn) begin
            bus_reg[p] <= BUSNUM_RST;
            ty_reg[p]  <= TY_RST;
         end else if (hot_reset) begin
            bus_reg[p] <= BUSNUM_RST;
            ty_reg[p]  <= ty_reg[p] & TY_STICKY;
         end else begin
            if (wr_hit[p] && w_off[p] == BUSNUM_OFF) bus_reg[p] <= w_dat[p][23:0];
            ty_reg[p] <= ty_next;
         end
      end
   end

   // upstream window base and its shadow copies
   logic       bar_lo_wr;
   logic       bar_hi_wr;
   logic       sh_wr;
   logic [3:0] sh_widx;
   logic [3:0] sh_ridx;
   logic       sh_rin;

   assign bar_lo_wr = wr_hit[UP_PORT] && w_off[UP_PORT] == BAR_LO_OFF;
   assign bar_hi_wr = wr_hit[UP_PORT] && w_off[UP_PORT] == BAR_HI_OFF;
   assign sh_wr     = wr_hit[0] && w_off[0] >= SHADOW_OFF && w_off[0] <= SHADOW_LAST;
   assign sh_widx   = 4'((w_off[0] - SHADOW_OFF) >> 2);
   assign sh_rin    = acc_port == 3'h0 && acc_off >= SHADOW_OFF && acc_off <= SHADOW_LAST;
   assign sh_ridx   = 4'((acc_off - SHADOW_OFF) >> 2);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         bar_lo_reg <= 32'h00000000;
         bar_hi_reg <= 32'h00000000;
      end else if (hot_reset) begin
         bar_lo_reg <= 32'h00000000;
         bar_hi_reg <= 32'h00000000;
      end else begin
         if (bar_lo_wr) bar_lo_reg <= w_dat[UP_PORT] & BASE_LO_MASK;
         if (bar_hi_wr) bar_hi_reg <= w_dat[UP_PORT];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < SHADOW_WORDS; i++) shadow_reg[i] <= 32'h00000000;
      end else if (hot_reset) begin
         for (int i = 0; i < SHADOW_WORDS; i++) shadow_reg[i] <= 32'h00000000;
      end else begin
         // a serial load may also fill the slots directly
         if (sh_wr) shadow_reg[sh_widx] <= w_dat[0];
         // the copy follows every base write, whoever made it
         if (bar_lo_wr) shadow_reg[SH_LO] <= w_dat[UP_PORT] & BASE_LO_MASK;
         if (bar_hi_wr) shadow_reg[SH_HI] <= w_dat[UP_PORT];
      end
   end

   // read data; registers held elsewhere in the switch read zero here
   logic [31:0] rd;
   always_comb begin
      rd = 32'h00000000;
      if (port_ok) begin
         if (acc_off == BAR_LO_OFF && acc_port == UP_PORT) rd = bar_lo_reg | BASE_LO_TYPE;
         else if (acc_off == BAR_HI_OFF && acc_port == UP_PORT) rd = bar_hi_reg;
         else if (acc_off == BUSNUM_OFF) rd = {8'h00, bus_reg[acc_port]};
         else if (acc_off == TYPED_OFF) rd = ty_reg[acc_port];
         else if (sh_rin) rd = shadow_reg[sh_ridx];
      end
      if (acc_off == READ_ZERO_OFF || acc_off == W1S_CLR_OFF) rd = 32'h00000000;
   end

   // answers and forwarded requests, one cycle after the request
   logic do_cpl;
   logic do_fwd;
   assign do_cpl = req_valid && !hot_reset
                   && (route == RT_LOCAL || route == RT_UR || route == RT_ZERO);
   assign do_fwd = req_valid && !hot_reset && (route == RT_FWD0 || route == RT_FWD1);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cpl_valid <= 1'b0;
         cpl       <= '0;
         fwd_valid <= 1'b0;
         fwd       <= '0;
         loc_valid <= 1'b0;
         loc_port  <= 3'h0;
      end else begin
         cpl_valid   <= do_cpl;
         cpl.status  <= route == RT_UR ? CPL_UR : CPL_SC;
         cpl.rdata   <= route == RT_LOCAL && !req.we ? rd : 32'h00000000;
         fwd_valid   <= do_fwd;
         fwd.port    <= rng_port;
         fwd.type0   <= route == RT_FWD0;
         fwd.bus     <= req.bus;
         fwd.dev     <= req.dev;
         fwd.func    <= req.func;
         fwd.offset  <= cfg_off;
         fwd.we      <= req.we;
         fwd.wdata   <= req.wdata;
         loc_valid   <= req_valid && !hot_reset && route == RT_LOCAL;
         loc_port    <= acc_port;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cap_bus <= 8'h00;
         cap_dev <= 5'h00;
      end else if (hot_reset) begin
         cap_bus <= 8'h00;
         cap_dev <= 5'h00;
      end else if (req_valid && req.kind == REQ_CFG0 && req.we) begin
         cap_bus <= req.bus;
         cap_dev <= req.dev;
      end
   end

   default clocking dflt @(posedge mclk); endclocking
   default disable iff (!rstn);

   chk_legacy_low: assert property (
      req_valid && req.kind != REQ_MEM && req.mech == MECH_LEGACY |-> acc_off[11:8] == 4'h0)
      else $error("legacy access reached past byte ff");
   chk_capture_ids: assert property (
      req_valid && !hot_reset && req.kind == REQ_CFG0 && req.we
      |=> cap_bus == $past(req.bus) && cap_dev == $past(req.dev))
      else $error("bus and device numbers not captured");
   chk_internal_local: assert property (
      req_valid && !hot_reset && req.kind == REQ_CFG1 && req.bus == int_bus && dev_ok
      && !enh_vendor |=> loc_valid && loc_port == $past(req.dev[2:0]) && !fwd_valid)
      else $error("internal bus request not taken locally");
   chk_unknown_dev: assert property (
      req_valid && !hot_reset && req.kind == REQ_CFG1 && req.bus == int_bus && !dev_ok
      |=> cpl_valid && cpl.status == CPL_UR && !loc_valid)
      else $error("unknown device not rejected");
   chk_fwd_unchanged: assert property (
      do_fwd && !sec_match |=> fwd_valid && !fwd.type0 && fwd.bus == $past(req.bus))
      else $error("subordinate request not forwarded as type 1");
   chk_fwd_type0: assert property (
      fwd_valid && fwd.type0 |-> fwd.dev == 5'h00 && !cpl_valid)
      else $error("type 0 conversion with nonzero device");
   chk_sec_nonzero: assert property (
      req_valid && !hot_reset && req.kind == REQ_CFG1 && req.bus != int_bus && rng_any
      && sec_match && req.dev != 5'h00 |=> !fwd_valid && cpl.status == CPL_UR)
      else $error("nonzero device on secondary bus not dropped");
   chk_vendor_hidden: assert property (
      req_valid && !hot_reset && enh_vendor && (req.kind == REQ_CFG0
      || req.kind == REQ_CFG1 && req.bus == int_bus && dev_ok)
      |=> cpl_valid && cpl.rdata == 32'h00000000 && !loc_valid)
      else $error("enhanced access reached vendor space");
   chk_slice_port: assert property (
      req_valid && !hot_reset && req.kind == REQ_MEM && win_hit && slice_ok
      |=> loc_valid && loc_port == $past(req.addr[14:12]))
      else $error("window slice routed to wrong port");
   chk_bar_shadow: assert property (
      bar_lo_wr && !hot_reset |=> shadow_reg[SH_LO] == bar_lo_reg)
      else $error("shadow copy differs from base");
   chk_hwi_locked: assert property (
      hw_locked_reg && !hot_reset |=> $stable(ty_reg[1] & TY_HWI))
      else $error("locked field changed");
   chk_w1c_clear: assert property (
      sw_hit[1] && w_off[1] == TYPED_OFF && w_dat[1][4] && !ev_set[1][0]
      |=> !ty_reg[1][4])
      else $error("write one did not clear status");
   chk_sticky_hot: assert property (
      hot_reset |=> (ty_reg[1] & TY_STICKY) == $past(ty_reg[1] & TY_STICKY))
      else $error("sticky field lost on hot reset");
   chk_w1s_set: assert property (
      sw_hit[1] && w_off[1] == TYPED_OFF && w_dat[1][16] |=> ty_reg[1][16])
      else $error("write one did not set control");
   chk_rsvd_zero: assert property (
      (ty_reg[0] & TY_RSVD) == 32'h00000000)
      else $error("reserved bit reads nonzero");
   chk_read_zero: assert property (
      req_valid && !hot_reset && route == RT_LOCAL && acc_off == READ_ZERO_OFF
      |=> cpl_valid && cpl.status == CPL_SC && cpl.rdata == 32'h00000000)
      else $error("read-zero register returned data");
   chk_reserved_zero: assert property (
      req_valid && !hot_reset && req.kind == REQ_MEM && win_hit && !slice_ok
      |=> cpl_valid && cpl.status == CPL_SC && cpl.rdata == 32'h00000000)
      else $error("reserved window access not zero");

   cov_fwd_type0: cover property (fwd_valid && fwd.type0);
   cov_unsupported: cover property (cpl_valid && cpl.status == CPL_UR);
   cov_window_read: cover property (loc_valid && cpl_valid && cpl.rdata != 32'h00000000);
   cov_bar_write: cover property (bar_lo_wr ##1 bar_hi_wr);
endmodule : switch_config_access_router

// *** verif/upstream_requester.sv ***
// upstream requester model: issues one request and records the answer
module upstream_requester
   import switch_cfg_pkg::*;
(
   input  wire logic     mclk,
   output logic          req_valid,
   output cfg_req_t      req,
   input  wire logic     cpl_valid,
   input  wire cpl_t     cpl,
   input  wire logic     fwd_valid,
   input  wire fwd_req_t fwd
);
   timeunit 1ns;
   timeprecision 1ns;
   logic     got_cpl;
   logic     got_fwd;
   cpl_t     cpl_seen;
   fwd_req_t fwd_seen;
   initial begin
      req_valid = 1'b0;
      req       = '0;
   end
   // one-cycle strobe, answer sampled one cycle later on the falling edge
   task automatic issue(input cfg_req_t r);
      @(negedge mclk);
      req_valid = 1'b1;
      req       = r;
      @(negedge mclk);
      req_valid = 1'b0;
      req       = ~r; // stale payload must not look like the last request
      got_cpl   = cpl_valid;
      got_fwd   = fwd_valid;
      cpl_seen  = cpl;
      fwd_seen  = fwd;
   endtask : issue
endmodule : upstream_requester

// *** verif/test_switch_config_access_router.sv ***
// self-checking bench for the configuration access router
module test_switch_config_access_router
   import switch_cfg_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [63:0] BASE = 64'h0000_0001_8002_0000;
   localparam logic [63:0] P1   = BASE + 64'h11f0;
   localparam logic [2:0]  FWD  = 3'h7;
   logic        mclk      = 1'b0;
   logic        rstn      = 1'b1;
   logic        hot_reset = 1'b0;
   logic        req_valid;
   cfg_req_t    req;
   logic        ld_valid  = 1'b0;
   logic [2:0]  ld_port   = 3'h1;
   logic [11:0] ld_offset = TYPED_OFF;
   logic [31:0] ld_data   = 32'h0;
   logic        ld_done   = 1'b0;
   logic [7:0]  ev_set [5] = '{default: 8'h00};
   logic [1:0]  sticky_ro_in [5] = '{default: 2'h1};
   logic        cpl_valid;
   cpl_t        cpl;
   logic        fwd_valid;
   fwd_req_t    fwd;
   logic        loc_valid;
   logic [2:0]  loc_port;
   logic [7:0]  cap_bus;
   logic [4:0]  cap_dev;
   int          err_total  = 0;
   int          num_checks = 0;
   always #50 mclk = ~mclk;
   switch_config_access_router switch_config_access_router_inst (.mclk(mclk), .rstn(rstn),
      .hot_reset(hot_reset), .req_valid(req_valid), .req(req), .ld_valid(ld_valid),
      .ld_port(ld_port), .ld_offset(ld_offset), .ld_data(ld_data), .ld_done(ld_done),
      .ev_set(ev_set), .sticky_ro_in(sticky_ro_in), .cpl_valid(cpl_valid), .cpl(cpl),
      .fwd_valid(fwd_valid), .fwd(fwd), .loc_valid(loc_valid), .loc_port(loc_port),
      .cap_bus(cap_bus), .cap_dev(cap_dev));
   upstream_requester upstream_requester_inst (.mclk(mclk), .req_valid(req_valid),
      .req(req), .cpl_valid(cpl_valid), .cpl(cpl), .fwd_valid(fwd_valid), .fwd(fwd));
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // status FWD means no completion is expected; rdata only matters on success
   task automatic send(input cfg_req_t r, input logic [2:0] st, input logic [31:0] rd);
      upstream_requester_inst.issue(r);
      if (st == FWD) begin
         check(upstream_requester_inst.got_cpl, 1'b0);
      end else begin
         check({upstream_requester_inst.got_cpl, upstream_requester_inst.cpl_seen.status,
                st == CPL_SC ? upstream_requester_inst.cpl_seen.rdata : 32'h0}, {1'b1, st, rd});
      end
   endtask : send
   task automatic cx(input req_kind_t k, input mech_t m, input logic [7:0] b, input logic [4:0] d,
                     input logic [11:0] o, input logic w, input logic [31:0] wd,
                     input logic [2:0] st, input logic [31:0] rd);
      send('{kind: k, mech: m, bus: b, dev: d, func: 3'h0, offset: o, addr: 64'h0, we: w,
             wdata: wd}, st, rd);
   endtask : cx
   task automatic mx(input logic [63:0] a, input logic w, input logic [31:0] wd,
                     input logic [2:0] st, input logic [31:0] rd);
      send('{kind: REQ_MEM, mech: MECH_LEGACY, bus: 8'h0, dev: 5'h0, func: 3'h0, offset: 12'h0,
             addr: a, we: w, wdata: wd}, st, rd);
   endtask : mx
   task automatic fx(input logic [2:0] p, input logic t0, input logic [7:0] b, input logic [4:0] d);
      check({upstream_requester_inst.got_fwd, upstream_requester_inst.fwd_seen.port,
             upstream_requester_inst.fwd_seen.type0, upstream_requester_inst.fwd_seen.bus,
             upstream_requester_inst.fwd_seen.dev}, {1'b1, p, t0, b, d});
   endtask : fx
   task automatic pulse_ld(input logic [31:0] d, input logic done);
      @(negedge mclk);
      ld_valid = ~done;
      ld_done  = done;
      ld_data  = d;
      @(negedge mclk);
      ld_valid = 1'b0;
   endtask : pulse_ld
   task automatic prog_base();
      cx(REQ_CFG0, MECH_LEGACY, 8'h07, 5'h03, BAR_LO_OFF, 1'b1, 32'h8002_0000, CPL_SC, 32'h0);
      cx(REQ_CFG0, MECH_LEGACY, 8'h07, 5'h03, BAR_HI_OFF, 1'b1, 32'h0000_0001, CPL_SC, 32'h0);
   endtask : prog_base
   task automatic conclude();
      if (err_total == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude
   initial begin
      #200000;
      err_total++;
      conclude();
   end
   initial begin
      // a real falling edge, so the asynchronous clear is seen
      #10 rstn = 1'b0;
      repeat (3) @(negedge mclk);
      check({cpl_valid, fwd_valid, loc_valid, cap_bus, cap_dev}, 16'h0);
      rstn = 1'b1;
      cx(REQ_CFG0, MECH_LEGACY, 8'h07, 5'h03, BUSNUM_OFF, 1'b1, 32'h0005_0100, CPL_SC, 32'h0);
      check({cap_bus, cap_dev}, {8'h07, 5'h03});
      cx(REQ_CFG0, MECH_LEGACY, 8'h07, 5'h03, 12'h118, 1'b0, 32'h0, CPL_SC, 32'h0005_0100);
      check({loc_valid, loc_port}, 4'h8);
      cx(REQ_CFG1, MECH_LEGACY, 8'h01, 5'h02, BUSNUM_OFF, 1'b1, 32'h0003_0201, CPL_SC, 32'h0);
      check({loc_valid, loc_port}, 4'ha);
      foreach (ev_set[i]) begin
         cx(REQ_CFG1, MECH_LEGACY, 8'h01, 5'(i * 5), 12'h000, 1'b0, 32'h0, CPL_UR, 32'h0);
      end
      cx(REQ_CFG1, MECH_LEGACY, 8'h02, 5'h00, 12'h004, 1'b0, 32'h0, FWD, 32'h0);
      fx(3'h2, 1'b1, 8'h02, 5'h00);
      cx(REQ_CFG1, MECH_LEGACY, 8'h03, 5'h04, 12'h004, 1'b0, 32'h0, FWD, 32'h0);
      fx(3'h2, 1'b0, 8'h03, 5'h04);
      cx(REQ_CFG1, MECH_LEGACY, 8'h02, 5'h03, 12'h004, 1'b0, 32'h0, CPL_UR, 32'h0);
      check(upstream_requester_inst.got_fwd, 1'b0);
      cx(REQ_CFG0, MECH_LEGACY, 8'h07, 5'h03, BAR_LO_OFF, 1'b1, 32'hffff_ffff, CPL_SC, 32'h0);
      cx(REQ_CFG0, MECH_LEGACY, 8'h07, 5'h03, BAR_LO_OFF, 1'b0, 32'h0, CPL_SC, 32'hfffe_0004);
      prog_base();
      mx(BASE + 64'h6c4, 1'b0, 32'h0, CPL_SC, 32'h0000_0001);
      mx(BASE + 64'h2018, 1'b0, 32'h0, CPL_SC, 32'h0003_0201);
      mx(BASE + 64'h5018, 1'b1, 32'hffff_ffff, CPL_SC, 32'h0);
      mx(BASE + 64'h1fffc, 1'b0, 32'h0, CPL_SC, 32'h0);
      mx(BASE + 64'h20000, 1'b0, 32'h0, CPL_UR, 32'h0);
      cx(REQ_CFG1, MECH_ENHANCED, 8'h01, 5'h01, TYPED_OFF, 1'b1, 32'hf, CPL_SC, 32'h0);
      pulse_ld(32'h0a00_0000, 1'b0);
      pulse_ld(32'h0, 1'b1);
      pulse_ld(32'h0500_0000, 1'b0);
      mx(P1, 1'b0, 32'h0, CPL_SC, 32'h1a00_0000);
      mx(P1, 1'b1, 32'hffff_ffff, CPL_SC, 32'h0);
      @(negedge mclk);
      ev_set[1] = 8'h31;
      @(negedge mclk);
      ev_set[1] = 8'h00;
      mx(P1, 1'b0, 32'h0, CPL_SC, 32'h1a0f_3f1f);
      mx(P1, 1'b1, 32'h0000_1010, CPL_SC, 32'h0);
      mx(P1, 1'b0, 32'h0, CPL_SC, 32'h1a0f_2000);
      mx(P1 + 64'h4, 1'b1, 32'h0005_0000, CPL_SC, 32'h0);
      mx(P1, 1'b0, 32'h0, CPL_SC, 32'h1a0a_2000);
      mx(P1 + 64'h8, 1'b1, 32'hffff_ffff, CPL_SC, 32'h0);
      mx(P1 + 64'h8, 1'b0, 32'h0, CPL_SC, 32'h0);
      mx(P1, 1'b1, 32'h0000_0f0f, CPL_SC, 32'h0);
      @(negedge mclk);
      hot_reset = 1'b1;
      @(negedge mclk);
      hot_reset = 1'b0;
      mx(P1, 1'b0, 32'h0, CPL_UR, 32'h0);
      prog_base();
      mx(P1, 1'b0, 32'h0, CPL_SC, 32'h1a0a_2f00);
      ld_port   = 3'h0;
      ld_offset = BAR_HI_OFF;
      pulse_ld(32'h0000_0002, 1'b0);
      ld_offset = SHADOW_OFF + 12'h004;
      pulse_ld(32'h0000_0002, 1'b0);
      cx(REQ_CFG0, MECH_LEGACY, 8'h07, 5'h03, BAR_HI_OFF, 1'b0, 32'h0, CPL_SC, 32'h2);
      mx(BASE + 64'h1_0000_06c4, 1'b0, 32'h0, CPL_SC, 32'h0000_0002);
      conclude();
   end
endmodule : test_switch_config_access_router
